// >>> rtl/sptx_pkg.sv
// Constants and types of the serial port transmit/receive data path
package sptx_pkg;
   localparam logic [1:0] SP_ADDR_DATA = 2'h0;
   localparam logic [1:0] SP_ADDR_STAT = 2'h1;
   localparam logic [1:0] SP_ADDR_CTLB = 2'h2;
   localparam logic [1:0] SP_ADDR_CTLC = 2'h3;
   localparam int ST_RXC   = 7;
   localparam int ST_TXC   = 6;
   localparam int ST_TX_BUFFER_EMPTY_FLAG  = 5;
   localparam int ST_FE    = 4;
   localparam int ST_DOR   = 3;
   localparam int ST_PE    = 2;
   localparam int CB_TX_DONE_IRQ_EN = 6;
   localparam int CB_TX_BUFFER_EMPTY_IRQ_EN = 5;
   localparam int CB_RECEIVER_ENABLE  = 4;
   localparam int CB_TRANSMITTER_ENABLE  = 3;
   localparam int CB_CSZ2  = 2;
   localparam int CB_RX_NINTH_BIT  = 1;
   localparam int CB_TX_NINTH_BIT  = 0;
   localparam int CC_SYNC  = 6;
   localparam int CC_PEN   = 5;
   localparam int CC_PODD  = 4;
   localparam int CC_SBS   = 3;
   localparam int CC_CSZ   = 1;
   localparam int FE_DOR   = 11;
   localparam int FE_FE    = 10;
   localparam int FE_PE    = 9;
   localparam int FE_NINTH = 8;
   localparam logic [7:0] CTLB_RST = 8'h00;
   localparam logic [7:0] CTLC_RST = 8'h06;
   localparam logic [2:0] CSZ_NINE = 3'h7;
   localparam logic [3:0] NBITS_BASE = 4'h5;
   localparam logic [3:0] NBITS_NINE = 4'h9;
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
   typedef enum logic [2:0] {
      TX_IDLE  = 3'h0,
      TX_START = 3'h1,
      TX_DATA  = 3'h3,
      TX_PAR   = 3'h2,
      TX_STOP  = 3'h6
   } sptx_tx_e;
   typedef enum logic [1:0] {
      RX_IDLE = 2'h0,
      RX_DATA = 2'h1,
      RX_PAR  = 2'h3,
      RX_STOP = 2'h2
   } sptx_rx_e;
endpackage

// >>> rtl/sptx_core.sv
// Serial port transmit and receive data path with register port
//
// Summary of operation
// - Buffer-empty flag mirrors empty transmit buffer
// - Data write fills buffer, clears empty flag
// - Buffer-empty request held while enabled and empty
// - Done flag set after frame, buffer empty
// - Done cleared by service or writing one
// - Done request raised while enabled and set
// - Parity bit sent after last data bit
// - Transmit disable waits for pending data
// - Disabled transmitter releases the output pin
// - Receive enable takes over input pin
// - Synchronous mode clocks bits by clock pin
// - Reception starts on start bit, shifts bits
// - Only first stop bit is examined
// - First stop bit moves frame to buffer
// - Unused upper data bits read as zero
// - Ninth bit and errors stored per entry
// - Start low, data LSB first, stop high
// - Parity is data xor, inverted for odd
// - Buffer reloads right after last stop
// - Receive-complete set while unread data remain
`timescale 1ns/1ps
module sptx_core
   import sptx_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   input  wire logic       clk_en,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       bit_tick,
   input  wire logic       sync_clock_pin,
   input  wire logic       rxd_pin,
   input  wire logic       irq_ack_txc,
   output logic            txd,
   output logic            txd_oe_n,
   output logic            rx_takeover,
   output logic            irq_tx_buffer_empty_flag,
   output logic            irq_txc
);
   logic [7:0]  ctrl_b;
   logic [7:0]  ctrl_c;
   logic [8:0]  tx_buf;
   logic        buf_full;
   logic        tx_done;
   logic        tx_on;
   sptx_tx_e    tx_st;
   logic [8:0]  tx_sh;
   logic [3:0]  tx_cnt;
   logic        tx_par;
   sptx_rx_e    rx_st;
   logic [8:0]  rx_sh;
   logic [3:0]  rx_cnt;
   logic        rx_par;
   logic        rx_perr;
   logic        hold;
   logic [10:0] hframe;
   logic        dor_pend;
   logic [11:0] fifo [FIFO_DEPTH];
   logic        rptr;
   logic        wptr;
   logic [1:0]  fcnt;
   logic        rxd_s1;
   logic        rxd_s2;
   logic        xck_s1;
   logic        xck_s2;
   logic        xck_s3;

   logic [7:0]  next_ctrl_b;
   logic [7:0]  next_ctrl_c;
   logic [8:0]  next_tx_buf;
   logic        next_buf_full;
   logic        next_tx_done;
   logic        next_tx_on;
   sptx_tx_e    next_tx_st;
   logic [8:0]  next_tx_sh;
   logic [3:0]  next_tx_cnt;
   logic        next_tx_par;
   logic        next_txd;
   sptx_rx_e    next_rx_st;
   logic [8:0]  next_rx_sh;
   logic [3:0]  next_rx_cnt;
   logic        next_rx_par;
   logic        next_rx_perr;
   logic        next_hold;
   logic [10:0] next_hframe;
   logic        next_dor_pend;
   logic [11:0] next_fifo [FIFO_DEPTH];
   logic        next_rptr;
   logic        next_wptr;
   logic [1:0]  next_fcnt;
   logic [7:0]  next_rdata;

   logic [2:0]  csz;
   logic [3:0]  nbits;
   logic        tx_tick;
   logic        rx_tick;
   logic        load;
   logic [11:0] head;
   logic [7:0]  dmask;

   always_comb
   begin
      csz = {ctrl_b[CB_CSZ2], ctrl_c[CC_CSZ+1:CC_CSZ]};
      if (csz == CSZ_NINE)
         nbits = NBITS_NINE;
      else
         nbits = NBITS_BASE + {2'h0, csz[1:0]};
      // Sync mode: change on rising, sample on falling clock pin edge
      if (ctrl_c[CC_SYNC])
      begin
         tx_tick = xck_s2 & ~xck_s3;
         rx_tick = ~xck_s2 & xck_s3;
      end
      else
      begin
         tx_tick = bit_tick;
         rx_tick = bit_tick;
      end
      load = buf_full & tx_on;
      head = (fcnt != 2'h0) ? fifo[rptr] : 12'h000;
      dmask = (nbits >= 4'h8) ? 8'hff
            : 8'(({4'h0, 4'h1} << nbits) - 8'h01);
   end

   always_comb
   begin
      next_ctrl_b = ctrl_b;
      next_ctrl_c = ctrl_c;
      next_tx_buf = tx_buf;
      next_buf_full = buf_full;
      next_tx_done = tx_done;
      next_tx_st = tx_st;
      next_tx_sh = tx_sh;
      next_tx_cnt = tx_cnt;
      next_tx_par = tx_par;
      next_txd = txd;
      next_rx_st = rx_st;
      next_rx_sh = rx_sh;
      next_rx_cnt = rx_cnt;
      next_rx_par = rx_par;
      next_rx_perr = rx_perr;
      next_hold = hold;
      next_hframe = hframe;
      next_dor_pend = dor_pend;
      next_fifo = fifo;
      next_rptr = rptr;
      next_wptr = wptr;
      next_fcnt = fcnt;
      next_rdata = 8'h00;

      // Transmitter
      if (tx_tick)
      begin
         case (tx_st)
            TX_IDLE:
            begin
               next_txd = 1'b1;
               if (load)
               begin
                  next_tx_sh = tx_buf;
                  next_buf_full = 1'b0;
                  next_txd = 1'b0;
                  next_tx_st = TX_START;
               end
            end
            TX_START, TX_DATA:
            begin
               if (tx_st == TX_DATA && tx_cnt == nbits)
               begin
                  if (ctrl_c[CC_PEN])
                  begin
                     next_txd = tx_par ^ ctrl_c[CC_PODD];
                     next_tx_st = TX_PAR;
                  end
                  else
                  begin
                     next_txd = 1'b1;
                     next_tx_st = TX_STOP;
                  end
                  next_tx_cnt = 4'h0;
               end
               else
               begin
                  next_txd = tx_sh[0];
                  next_tx_sh = {1'b0, tx_sh[8:1]};
                  next_tx_par = (tx_st == TX_START) ? tx_sh[0]
                              : tx_par ^ tx_sh[0];
                  next_tx_cnt = (tx_st == TX_START) ? 4'h1
                              : tx_cnt + 4'h1;
                  next_tx_st = TX_DATA;
               end
            end
            TX_PAR:
            begin
               next_txd = 1'b1;
               next_tx_cnt = 4'h0;
               next_tx_st = TX_STOP;
            end
            TX_STOP:
            begin
               if (tx_cnt == 4'h0 && ctrl_c[CC_SBS])
                  next_tx_cnt = 4'h1;
               else if (load)
               begin
                  next_tx_sh = tx_buf;
                  next_buf_full = 1'b0;
                  next_txd = 1'b0;
                  next_tx_st = TX_START;
               end
               else
               begin
                  next_tx_done = 1'b1;
                  next_tx_st = TX_IDLE;
               end
            end
            default:
            begin
               next_txd = 1'b1;
               next_tx_st = TX_IDLE;
            end
         endcase
      end

      // Software access
      if (wr && addr == SP_ADDR_DATA)
      begin
         next_tx_buf = {ctrl_b[CB_TX_NINTH_BIT], wdata};
         next_buf_full = 1'b1;
      end
      if (wr && addr == SP_ADDR_CTLB)
      begin
         next_ctrl_b = wdata;
         next_ctrl_b[CB_RX_NINTH_BIT] = 1'b0;
      end
      if (wr && addr == SP_ADDR_CTLC)
         next_ctrl_c = wdata;
      // Set by the finishing frame wins over either clear
      if (irq_ack_txc || (wr && addr == SP_ADDR_STAT && wdata[ST_TXC]))
         next_tx_done = (tx_tick && tx_st == TX_STOP && next_tx_done
                         && next_tx_st == TX_IDLE);
      next_tx_on = next_ctrl_b[CB_TRANSMITTER_ENABLE] | (next_tx_st != TX_IDLE)
                 | next_buf_full;

      // Held frame enters the FIFO once there is room
      if (hold && fcnt != FIFO_DEPTH)
      begin
         next_fifo[wptr] = {dor_pend, hframe};
         next_wptr = ~wptr;
         next_hold = 1'b0;
         next_dor_pend = 1'b0;
      end

      // Receiver
      if (rx_tick)
      begin
         case (rx_st)
            RX_IDLE:
            begin
               if (!rxd_s2)
               begin
                  if (next_hold)
                     next_dor_pend = 1'b1;
                  next_rx_sh = 9'h000;
                  next_rx_cnt = 4'h0;
                  next_rx_par = 1'b0;
                  next_rx_perr = 1'b0;
                  next_rx_st = RX_DATA;
               end
            end
            RX_DATA:
            begin
               next_rx_sh[rx_cnt] = rxd_s2;
               next_rx_par = rx_par ^ rxd_s2;
               next_rx_cnt = rx_cnt + 4'h1;
               if (rx_cnt + 4'h1 == nbits)
                  next_rx_st = ctrl_c[CC_PEN] ? RX_PAR : RX_STOP;
            end
            RX_PAR:
            begin
               next_rx_perr = rxd_s2 ^ rx_par ^ ctrl_c[CC_PODD];
               next_rx_st = RX_STOP;
            end
            RX_STOP:
            begin
               if (!next_hold)
               begin
                  next_hold = 1'b1;
                  next_hframe = {~rxd_s2, rx_perr, rx_sh};
               end
               next_rx_st = RX_IDLE;
            end
            default:
               next_rx_st = RX_IDLE;
         endcase
      end

      // Register reads, data read advances the FIFO
      if (rd)
      begin
         case (addr)
            SP_ADDR_DATA:
            begin
               next_rdata = head[7:0] & dmask;
               if (fcnt != 2'h0)
                  next_rptr = ~rptr;
            end
            SP_ADDR_STAT:
            begin
               next_rdata[ST_RXC] = (fcnt != 2'h0);
               next_rdata[ST_TXC] = tx_done;
               next_rdata[ST_TX_BUFFER_EMPTY_FLAG] = ~buf_full;
               next_rdata[ST_FE] = head[FE_FE];
               next_rdata[ST_DOR] = head[FE_DOR];
               next_rdata[ST_PE] = head[FE_PE];
            end
            SP_ADDR_CTLB:
            begin
               next_rdata = ctrl_b;
               next_rdata[CB_RX_NINTH_BIT] = head[FE_NINTH];
            end
            default:
               next_rdata = ctrl_c;
         endcase
      end
      next_fcnt = fcnt + {1'b0, next_wptr != wptr}
                - {1'b0, next_rptr != rptr};

      // Disabled receiver aborts and flushes at once
      if (!ctrl_b[CB_RECEIVER_ENABLE])
      begin
         next_rx_st = RX_IDLE;
         next_hold = 1'b0;
         next_dor_pend = 1'b0;
         next_fcnt = 2'h0;
         next_rptr = 1'b0;
         next_wptr = 1'b0;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         ctrl_b <= CTLB_RST;
         ctrl_c <= CTLC_RST;
         tx_buf <= 9'h000;
         buf_full <= 1'b0;
         tx_done <= 1'b0;
         tx_on <= 1'b0;
         tx_st <= TX_IDLE;
         tx_sh <= 9'h000;
         tx_cnt <= 4'h0;
         tx_par <= 1'b0;
         txd <= 1'b1;
         txd_oe_n <= 1'b1;
         rx_takeover <= 1'b0;
         irq_tx_buffer_empty_flag <= 1'b0;
         irq_txc <= 1'b0;
         rx_st <= RX_IDLE;
         rx_sh <= 9'h000;
         rx_cnt <= 4'h0;
         rx_par <= 1'b0;
         rx_perr <= 1'b0;
         hold <= 1'b0;
         hframe <= 11'h000;
         dor_pend <= 1'b0;
         fifo <= '{default: 12'h000};
         rptr <= 1'b0;
         wptr <= 1'b0;
         fcnt <= 2'h0;
         rdata <= 8'h00;
         rxd_s1 <= 1'b1;
         rxd_s2 <= 1'b1;
         xck_s1 <= 1'b0;
         xck_s2 <= 1'b0;
         xck_s3 <= 1'b0;
      end
      else if (clk_en)
      begin
         ctrl_b <= next_ctrl_b;
         ctrl_c <= next_ctrl_c;
         tx_buf <= next_tx_buf;
         buf_full <= next_buf_full;
         tx_done <= next_tx_done;
         tx_on <= next_tx_on;
         tx_st <= next_tx_st;
         tx_sh <= next_tx_sh;
         tx_cnt <= next_tx_cnt;
         tx_par <= next_tx_par;
         txd <= next_txd;
         txd_oe_n <= ~next_tx_on;
         rx_takeover <= next_ctrl_b[CB_RECEIVER_ENABLE];
         irq_tx_buffer_empty_flag <= next_ctrl_b[CB_TX_BUFFER_EMPTY_IRQ_EN] & ~next_buf_full;
         irq_txc <= next_ctrl_b[CB_TX_DONE_IRQ_EN] & next_tx_done;
         rx_st <= next_rx_st;
         rx_sh <= next_rx_sh;
         rx_cnt <= next_rx_cnt;
         rx_par <= next_rx_par;
         rx_perr <= next_rx_perr;
         hold <= next_hold;
         hframe <= next_hframe;
         dor_pend <= next_dor_pend;
         fifo <= next_fifo;
         rptr <= next_rptr;
         wptr <= next_wptr;
         fcnt <= next_fcnt;
         rdata <= next_rdata;
         rxd_s1 <= rxd_pin;
         rxd_s2 <= rxd_s1;
         xck_s1 <= sync_clock_pin;
         xck_s2 <= xck_s1;
         xck_s3 <= xck_s2;
      end
   end
endmodule

// >>> verif/sptx_chk_sva.sv
// Assertion checker for the serial port data path ports
`timescale 1ns/1ps
module sptx_chk
   import sptx_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rstn,
   input wire logic       clk_en,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       bit_tick,
   input wire logic       sync_clock_pin,
   input wire logic       irq_ack_txc,
   input wire logic       txd,
   input wire logic       txd_oe_n,
   input wire logic       rx_takeover,
   input wire logic       irq_tx_buffer_empty_flag,
   input wire logic       irq_txc
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   a_reset_outputs: assert property (disable iff (1'b0)
      !rstn |=> rdata == 8'h00 && txd && txd_oe_n && !rx_takeover
      && !irq_tx_buffer_empty_flag && !irq_txc) else $error("outputs not at reset values");
   a_rdata_quiet: assert property (
      clk_en && !rd |=> rdata == 8'h00) else $error("stray read data");
   a_tx_buffer_empty_flag_write_fall: assert property (
      clk_en && wr && addr == SP_ADDR_DATA |=> !irq_tx_buffer_empty_flag)
      else $error("buffer empty request after data write");
   a_tx_buffer_empty_flag_rise_cause: assert property (
      $rose(irq_tx_buffer_empty_flag) |-> $past(bit_tick) || $past(bit_tick, 2)
      || $past(bit_tick, 3) || $past(wr) || $past(wr, 2) || $past(wr, 3))
      else $error("buffer empty request without cause");
   a_txc_clear_cause: assert property (
      $fell(irq_txc) |-> $past(irq_ack_txc) || $past(irq_ack_txc, 2)
      || $past(wr) || $past(wr, 2)) else $error("done request lost");
   a_txc_after_stop: assert property (
      $rose(irq_txc) |-> txd && $past(txd))
      else $error("done raised inside a frame");
   a_txd_on_tick: assert property (
      $changed(txd) |-> $past(bit_tick)
      || ($past(sync_clock_pin, 3) && !$past(sync_clock_pin, 4)))
      else $error("line moved off tick");
   a_takeover_follow: assert property (
      wr && addr == SP_ADDR_CTLB && clk_en ##1 !(wr && addr == SP_ADDR_CTLB)
      |=> rx_takeover == $past(wdata[CB_RECEIVER_ENABLE], 2))
      else $error("input pin takeover wrong");
   a_release_idle: assert property (
      $rose(txd_oe_n) |-> txd && $past(txd))
      else $error("output released inside a frame");
endmodule

bind sptx_core sptx_chk u_chk (.clk_sys(clk_sys), .rstn(rstn),
   .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .bit_tick(bit_tick), .sync_clock_pin(sync_clock_pin),
   .irq_ack_txc(irq_ack_txc),
   .txd(txd), .txd_oe_n(txd_oe_n), .rx_takeover(rx_takeover),
   .irq_tx_buffer_empty_flag(irq_tx_buffer_empty_flag), .irq_txc(irq_txc));

// >>> verif/sptx_remote.sv
// Remote serial transceiver model on the line side
`timescale 1ns/1ps
module sptx_remote (
   input  wire logic        clk_sys,
   input  wire logic        bit_tick,
   input  wire logic        txd,
   input  wire logic [3:0]  nb,
   input  wire logic        pen,
   input  wire logic        podd,
   output logic             rxd_pin,
   output logic             got_v,
   output logic      [10:0] got
);
   int idx = -1;
   initial rxd_pin = 1'b1;
   initial got_v = 1'b0;

   // Capture bits after a start, up to the first stop
   always @(posedge clk_sys)
   begin
      got_v <= 1'b0;
      if (bit_tick && idx < 0 && txd === 1'b0)
      begin
         idx <= 0;
         got <= 11'h000;
      end
      else if (bit_tick && idx >= 0)
      begin
         got[idx] <= txd;
         idx <= (idx == nb + pen) ? -1 : idx + 1;
         got_v <= (idx == nb + pen);
      end
   end

   // Idle line is high between frames
   task automatic send(input logic [8:0] d, input logic bad_par,
                       input logic bad_stop);
      logic [10:0] f;
      int          i;
      f = {2'b00, d & ((9'h001 << nb) - 9'h001)};
      if (pen)
         f[nb] = ^f ^ podd ^ bad_par;
      f[nb + pen] = ~bad_stop;
      @(posedge clk_sys iff bit_tick);
      rxd_pin <= 1'b0;
      for (i = 0; i <= nb + pen; i++)
      begin
         @(posedge clk_sys iff bit_tick);
         rxd_pin <= f[i];
      end
      @(posedge clk_sys iff bit_tick);
      rxd_pin <= 1'b1;
   endtask
endmodule

// >>> verif/sptx_core_test.sv
// Self-checking testbench of the serial port data path
`timescale 1ns/1ps
module sptx_core_test
   import sptx_pkg::*;
   ;
   logic clk_sys, rstn, clk_en, wr, rd, bit_tick, sync_clock_pin;
   logic irq_ack_txc, txd, txd_oe_n, rx_takeover, irq_tx_buffer_empty_flag, irq_txc;
   logic rxd_pin, pen, podd, got_v, rd_d;
   logic [1:0] addr, tick_cnt;
   logic [7:0] wdata, rdata;
   logic [3:0] nb;
   logic [2:0] sz;
   logic [8:0] d1, d2, mk;
   logic [10:0] got;
   logic [15:0] rq;
   logic [15:0] rd_q[$];
   logic [10:0] tx_q[$];
   int i, seed, check_count, n_mismatch;

   sptx_core DUT (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .bit_tick(bit_tick), .sync_clock_pin(sync_clock_pin),
      .rxd_pin(rxd_pin), .irq_ack_txc(irq_ack_txc), .txd(txd),
      .txd_oe_n(txd_oe_n), .rx_takeover(rx_takeover),
      .irq_tx_buffer_empty_flag(irq_tx_buffer_empty_flag), .irq_txc(irq_txc));
   sptx_remote u_remote (.clk_sys(clk_sys), .bit_tick(bit_tick),
      .txd(txd), .nb(nb), .pen(pen), .podd(podd), .rxd_pin(rxd_pin),
      .got_v(got_v), .got(got));

   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
   begin
      tick_cnt <= tick_cnt + 2'h1;
      bit_tick <= (tick_cnt == 2'h2);
      // Clock pin at the bit rate: changing (rising) edge lines up with bit_tick
      sync_clock_pin <= tick_cnt[1];
   end

   task end_sim;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task chk_v(input logic [10:0] g, input logic [10:0] e);
      check_count++;
      if (g !== e)
      begin
         $display("ERROR %0t: got %h expected %h", $time, g, e);
         n_mismatch++;
      end
   endtask

   task chk_f(input logic g, input logic e);
      check_count++;
      if (g !== e)
      begin
         $display("ERROR %0t: flag %b expected %b", $time, g, e);
         n_mismatch++;
      end
   endtask

   task wait_on(input int w, input logic v);
      int n;
      n = 0;
      // Let the edge that took the last request settle first
      @(negedge clk_sys);
      while (((w == 0) ? irq_tx_buffer_empty_flag : (w == 1) ? irq_txc : txd_oe_n) !== v
             && n < 2000)
      begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 2000)
      begin
         $display("ERROR %0t: wait timed out", $time);
         n_mismatch++;
         end_sim;
      end
   endtask

   task wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   task rd_reg(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      rd_q.push_back({e, m});
      @(posedge clk_sys);
      rd <= 1'b0;
   endtask

   function automatic logic [10:0] frame(input logic [8:0] d);
      logic [10:0] f;
      f = {2'b00, d & mk};
      if (pen)
         f[nb] = ^(d & mk) ^ podd;
      f[nb + pen] = 1'b1;
      return f;
   endfunction

   // Result watcher: oldest note against each read or received frame
   always @(posedge clk_sys)
   begin
      rd_d <= rd;
      if (rd_d)
      begin
         rq = rd_q.pop_front();
         chk_v({3'b000, rdata & rq[7:0]}, {3'b000, rq[15:8] & rq[7:0]});
      end
      if (got_v)
         chk_v(got, tx_q.pop_front());
   end

   initial
   begin
      seed = 50;
      rstn = 1'b0;
      clk_en = 1'b1;
      addr = 2'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      rd_d = 1'b0;
      tick_cnt = 2'h0;
      bit_tick = 1'b0;
      sync_clock_pin = 1'b0;
      irq_ack_txc = 1'b0;
      nb = 4'h8;
      pen = 1'b0;
      podd = 1'b0;
      check_count = 0;
      n_mismatch = 0;
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      rd_reg(SP_ADDR_STAT, 8'h20, 8'hfc);
      rd_reg(SP_ADDR_CTLB, CTLB_RST, 8'hff);
      rd_reg(SP_ADDR_CTLC, CTLC_RST, 8'h7e);
      for (i = 0; i < 5; i++)
      begin
         sz = (i == 4) ? CSZ_NINE : 3'(i);
         nb = (i == 4) ? NBITS_NINE : NBITS_BASE + 4'(i);
         pen = (i != 1);
         podd = i[0];
         mk = (9'h001 << nb) - 9'h001;
         d1 = 9'($random(seed));
         d2 = 9'($random(seed));
         wr_reg(SP_ADDR_CTLC, {1'b0, (i == 3), pen, podd, (i == 2), sz[1:0],
                               1'b0});
         wr_reg(SP_ADDR_CTLB, {5'b01111, sz[2], 1'b0, d1[8]});
         fork
            begin
               u_remote.send(d1, 1'b1, 1'b0);
               u_remote.send(d2, 1'b0, 1'b1);
            end
            begin
               tx_q.push_back(frame(d1));
               wr_reg(SP_ADDR_DATA, d1[7:0]);
               wait_on(0, 1'b1);
               wr_reg(SP_ADDR_CTLB, {5'b01111, sz[2], 1'b0, d2[8]});
               tx_q.push_back(frame(d2));
               wr_reg(SP_ADDR_DATA, d2[7:0]);
               wait_on(1, 1'b1);
            end
         join
         @(posedge clk_sys);
         irq_ack_txc <= 1'b1;
         @(posedge clk_sys);
         irq_ack_txc <= 1'b0;
         rd_reg(SP_ADDR_STAT, {5'b10100, pen, 2'b00}, 8'hfc);
         rd_reg(SP_ADDR_CTLB, {5'b01111, sz[2], d1[8], d2[8]},
                (i == 4) ? 8'h7f : 8'h7d);
         rd_reg(SP_ADDR_DATA, d1[7:0] & mk[7:0], 8'hff);
         rd_reg(SP_ADDR_STAT, 8'hb0, 8'hfc);
         rd_reg(SP_ADDR_DATA, d2[7:0] & mk[7:0], 8'hff);
         rd_reg(SP_ADDR_STAT, 8'h20, 8'hfc);
      end
      // Four frames into a two-entry FIFO: the fourth is lost
      for (i = 0; i < 4; i++)
         u_remote.send(9'(i), 1'b0, 1'b0);
      rd_reg(SP_ADDR_DATA, 8'h00, 8'hff);
      rd_reg(SP_ADDR_DATA, 8'h01, 8'hff);
      rd_reg(SP_ADDR_STAT, 8'ha8, 8'hfc);
      rd_reg(SP_ADDR_DATA, 8'h02, 8'hff);
      rd_reg(SP_ADDR_STAT, 8'h20, 8'hfc);
      // Disable while a character is still pending
      tx_q.push_back(frame({d2[8], d1[7:0]}));
      wr_reg(SP_ADDR_DATA, d1[7:0]);
      wr_reg(SP_ADDR_CTLB, 8'h54);
      @(negedge clk_sys);
      chk_f(txd_oe_n, 1'b0);
      wait_on(1, 1'b1);
      wait_on(2, 1'b1);
      chk_f(rx_takeover, 1'b1);
      wr_reg(SP_ADDR_STAT, 8'h00);
      repeat (2) @(negedge clk_sys);
      chk_f(irq_txc, 1'b1);
      wr_reg(SP_ADDR_STAT, 8'h40);
      repeat (2) @(negedge clk_sys);
      chk_f(irq_txc, 1'b0);
      // Frozen block ignores a write
      @(posedge clk_sys);
      clk_en <= 1'b0;
      wr_reg(SP_ADDR_CTLB, 8'h00);
      clk_en <= 1'b1;
      @(negedge clk_sys);
      chk_f(rx_takeover, 1'b1);
      wr_reg(SP_ADDR_CTLB, 8'h00);
      repeat (2) @(negedge clk_sys);
      chk_f(rx_takeover, 1'b0);
      chk_v(11'(tx_q.size()), 11'h000);
      end_sim;
   end
endmodule
